// ### dv/rsa_link_tx_model.sv
`timescale 1ns/1ps
`include "rsa_defines.svh"
module rsa_link_tx_model (
	input wire logic bit_clk_in,
	output logic serial_bit_out
);
	logic [39:0] q[$];
	// three stray bits first, so the receiver must find the boundary
	logic [39:0] word = 40'h5;
	int pos = 37;
	initial serial_bit_out = 1'b0;
	always @(posedge bit_clk_in) begin
		if (pos == 40) begin
			// idle time is filled with skip words
			if (q.size() > 0) begin
				word = q.pop_front();
			end else begin
				word = {`RSA_COMMA_PLUS, `RSA_SKIP_TAIL};
			end
			pos = 0;
		end
		serial_bit_out <= word[39 - pos];
		pos++;
	end
endmodule

// ### dv/rsa_rx_align_checker.sv
`timescale 1ns/1ps
`include "rsa_defines.svh"
module rsa_rx_align_checker (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic link_reinit_in,
	input wire logic user_ready_in,
	input wire rsa_pkg::rsa_entry_t rx_entry_out,
	input wire logic rx_entry_valid_out,
	input wire logic rx_aligned_out,
	input wire logic rx_overflow_out
);
	import rsa_pkg::*;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in || link_reinit_in);
	sequence s_wait;
		rx_entry_valid_out && !user_ready_in;
	endsequence
	sequence s_quiet;
		!rx_entry_valid_out [*3];
	endsequence
	property p_hold;
		s_wait |=> rx_entry_valid_out;
	endproperty
	property p_entry;
		s_wait |=> $stable(rx_entry_out);
	endproperty
	property p_rst;
		disable iff (1'b0) rst_in |=> !rx_entry_valid_out &&
			!rx_overflow_out && !rx_aligned_out;
	endproperty
	property p_prime;
		$fell(rst_in) |-> s_quiet;
	endproperty
	property p_sticky;
		rx_overflow_out |=> rx_overflow_out;
	endproperty
	property p_skip;
		rx_entry_valid_out && rx_entry_out.skip |->
			rx_entry_out.data[29:0] == `RSA_SKIP_TAIL &&
			is_comma(rx_entry_out.data[39:30]);
	endproperty
	property p_data;
		rx_entry_valid_out && !rx_entry_out.skip |->
			!(is_comma(rx_entry_out.data[39:30]) &&
			rx_entry_out.data[29:0] == `RSA_SKIP_TAIL);
	endproperty
	property p_align;
		rx_entry_valid_out |-> rx_aligned_out;
	endproperty
	a_hold: assert property (p_hold) else $error("valid dropped");
	a_entry: assert property (p_entry) else $error("entry moved");
	a_rst: assert property (p_rst) else $error("reset state");
	a_prime: assert property (p_prime) else $error("no priming");
	a_sticky: assert property (p_sticky) else $error("flag lost");
	a_skip: assert property (p_skip) else $error("bad skip word");
	a_data: assert property (p_data) else $error("skip unflagged");
	a_align: assert property (p_align) else $error("not aligned");
endmodule
bind rsa_rx_align_top rsa_rx_align_checker rsa_rx_align_checker_i (
	.ref_clk_in(ref_clk_in),
	.rst_in(rst_in),
	.link_reinit_in(link_reinit_in),
	.user_ready_in(user_ready_in),
	.rx_entry_out(rx_entry_out),
	.rx_entry_valid_out(rx_entry_valid_out),
	.rx_aligned_out(rx_aligned_out),
	.rx_overflow_out(rx_overflow_out)
);

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "rsa_defines.svh"
module testbench;
	import rsa_pkg::*;
	logic ref_clk_in = 1'b0;
	logic bit_clk = 1'b0;
	logic rst_in = 1'b1;
	logic reinit = 1'b0;
	logic mode = 1'b0;
	logic ready = 1'b0;
	logic serial;
	rsa_entry_t entry;
	logic valid;
	logic aligned;
	logic overflow;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	always #10 ref_clk_in = ~ref_clk_in;
	// link clock free of any phase tie to the user clock
	initial begin
		#3.3;
		forever #6 bit_clk = ~bit_clk;
	end
	rsa_rx_align_top rsa_rx_align_top_i (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.link_reinit_in(reinit),
		.align_mode_in(mode),
		.recovered_bit_clk_in(bit_clk),
		.serial_bit_in(serial),
		.user_ready_in(ready),
		.rx_entry_out(entry),
		.rx_entry_valid_out(valid),
		.rx_aligned_out(aligned),
		.rx_overflow_out(overflow)
	);
	rsa_link_tx_model rsa_link_tx_model_i (
		.bit_clk_in(bit_clk),
		.serial_bit_out(serial)
	);
	task automatic conclude();
		if (errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end
	task automatic chk(input string name, input logic [40:0] exp,
		input logic [40:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic restart(input logic m);
		rst_in = 1'b1;
		mode = m;
		ready = 1'b0;
		step(6);
		rst_in = 1'b0;
		step(1);
		chk("overflow", 41'h0, {40'h0, overflow});
		chk("valid", 41'h0, {40'h0, valid});
		for (int c = 0; c < 300 && !aligned; c++) step(1);
		step(100);
	endtask
	task automatic stream(input logic m, input int stall);
		logic [39:0] exp[$];
		logic [39:0] w;
		int got = 0;
		int skips = 0;
		restart(m);
		rsa_link_tx_model_i.q.delete();
		for (int i = 0; i < 16; i++) begin
			w = {10'h155 ^ 10'(i % 4), 10'h2aa ^ 10'(i / 4), 10'h155, 10'h2aa};
			exp.push_back(w);
			rsa_link_tx_model_i.q.push_back(w);
			rsa_link_tx_model_i.q.push_back({`RSA_COMMA_PLUS, `RSA_SKIP_TAIL});
		end
		ready = 1'b1;
		// a stall lifts the fill above half, so skips get dropped
		for (int c = 0; c < 3000 && got < 16; c++) begin
			if (c == 100) ready = 1'b0;
			if (c == 100 + stall) ready = 1'b1;
			if (valid && ready && entry.skip) skips++;
			if (valid && ready && !entry.skip) begin
				chk("word", {1'b0, exp[got]}, entry);
				got++;
			end
			step(1);
		end
		chk("words", 41'h10, 41'(got));
		chk("skips", 41'h1, {40'h0, skips > 0});
		chk("aligned", 41'h1, {40'h0, aligned});
	endtask
	task automatic flood();
		restart(1'b0);
		step(400);
		chk("overflow", 41'h1, {40'h0, overflow});
		reinit = 1'b1;
		step(6);
		reinit = 1'b0;
		step(1);
		chk("overflow", 41'h0, {40'h0, overflow});
		chk("valid", 41'h0, {40'h0, valid});
		chk("aligned", 41'h0, {40'h0, aligned});
		restart(1'b0);
	endtask
	initial begin
		stream(1'b0, 60);
		stream(1'b1, 60);
		flood();
		conclude();
	end
endmodule

// ### include/rsa_defines.svh
`ifndef RSA_DEFINES_SVH
`define RSA_DEFINES_SVH

`define RSA_CHAR_BITS 10
`define RSA_PAIR_BITS 20
`define RSA_OFFSETS 10
`define RSA_BIT_LAST 4'h9
`define RSA_COMMA_PLUS 10'h0fa
`define RSA_COMMA_MINUS 10'h305
`define RSA_WORD_BITS 40
`define RSA_WORD_LAST 2'h3
`define RSA_SKIP_TAIL 30'h2aaaaaaa
`define RSA_FIFO_DEPTH 8

`endif

// ### include/rsa_pkg.sv
`include "rsa_defines.svh"

package rsa_pkg;

	typedef struct packed {
		logic skip;
		logic [`RSA_WORD_BITS-1:0] data;
	} rsa_entry_t;

	typedef enum logic [1:0] {
		RSA_PRIME = 2'b00,
		RSA_RUN = 2'b01
	} rsa_rd_state_t;

	function automatic logic is_comma(input logic [`RSA_CHAR_BITS-1:0] c);
		return (c == `RSA_COMMA_PLUS) || (c == `RSA_COMMA_MINUS);
	endfunction

endpackage

// ### logic/rsa_rx_align.sv
`timescale 1ns/1ps
`include "rsa_defines.svh"

module rsa_sync3 #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	import rsa_pkg::*;
	logic [W-1:0] s1, s2, s3, next_q;

	always_comb begin
		next_q = q_out;
		// stage one is never looked at
		if (s2 == s3) begin
			next_q = s3;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q_out <= '0;
		end else begin
			s1 <= d_in;
			s2 <= s1;
			s3 <= s2;
			q_out <= next_q;
		end
	end
endmodule

module rsa_elastic_fifo #(
	parameter int WIDTH = 41,
	parameter int DEPTH = 8
) (
	input wire logic wr_clk_in,
	input wire logic wr_rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic rd_clk_in,
	input wire logic rd_rst_in,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	import rsa_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW:0] ONE = (AW+1)'(1);
	localparam logic [AW:0] TWO = (AW+1)'(2);

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [AW:0] from_gray(input logic [AW:0] g);
		logic [AW:0] b;
		b = g;
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin, next_wbin, wgray, rgray_w, rbin_w;
	logic [AW:0] rbin, next_rbin, rgray, wgray_r, wbin_r, fill;
	logic [AW:0] rtrail, next_rtrail;
	logic wr_go, next_valid;
	logic [AW-1:0] ahead_idx;
	logic [WIDTH-1:0] cur, ahead, next_data;
	rsa_rd_state_t state, next_state;

	rsa_sync3 #(.W(AW + 1)) u_rd_ptr_sync (
		.clk_in(wr_clk_in),
		.rst_in(wr_rst_in),
		.d_in(rgray),
		.q_out(rgray_w)
	);

	rsa_sync3 #(.W(AW + 1)) u_wr_ptr_sync (
		.clk_in(rd_clk_in),
		.rst_in(rd_rst_in),
		.d_in(wgray),
		.q_out(wgray_r)
	);

	always_comb begin
		rbin_w = from_gray(rgray_w);
		wr_ready_out = (wbin - rbin_w) != FULL;
		wr_go = wr_valid_in && wr_ready_out;
		next_wbin = wbin;
		if (wr_go) begin
			next_wbin = wbin + ONE;
		end
	end

	always_ff @(posedge wr_clk_in) begin
		if (wr_rst_in) begin
			wbin <= '0;
			wgray <= '0;
		end else begin
			wbin <= next_wbin;
			wgray <= to_gray(next_wbin);
		end
	end

	always_ff @(posedge wr_clk_in) begin
		if (wr_go) begin
			mem[wbin[AW-1:0]] <= wr_data_in;
		end
	end

	always_comb begin
		wbin_r = from_gray(wgray_r);
		fill = wbin_r - rbin;
		ahead_idx = rbin[AW-1:0] + 1'b1;
		cur = mem[rbin[AW-1:0]];
		ahead = mem[ahead_idx];
		next_state = state;
		next_rbin = rbin;
		next_data = rd_data_out;
		next_valid = rd_valid_out;
		case (state)
			RSA_PRIME: begin
				if (fill >= HALF) begin
					next_state = RSA_RUN;
				end
			end
			RSA_RUN: begin
				if (!rd_valid_out || rd_ready_in) begin
					next_valid = 1'b0;
					if (fill == '0) begin
						// underrun: refill to half before resuming
						next_state = RSA_PRIME;
					end else begin
						next_data = cur;
						next_valid = 1'b1;
						next_rbin = rbin + ONE;
						if (cur[WIDTH-1] && fill < HALF) begin
							next_rbin = rbin;
						end else if (fill > HALF && ahead[WIDTH-1]) begin
							next_rbin = rbin + TWO;
						end
					end
				end
			end
			default: begin
				next_state = RSA_PRIME;
			end
		endcase
		next_rtrail = rtrail;
		// one gray step a clock, a skip jump would tear the crossing word
		if (rtrail != next_rbin) begin
			next_rtrail = rtrail + ONE;
		end
	end

	always_ff @(posedge rd_clk_in) begin
		if (rd_rst_in) begin
			state <= RSA_PRIME;
			rbin <= '0;
			rtrail <= '0;
			rgray <= '0;
			rd_data_out <= '0;
			rd_valid_out <= 1'b0;
		end else begin
			state <= next_state;
			rbin <= next_rbin;
			rtrail <= next_rtrail;
			rgray <= to_gray(next_rtrail);
			rd_data_out <= next_data;
			rd_valid_out <= next_valid;
		end
	end
endmodule

module rsa_rx_align_top (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic link_reinit_in,
	input wire logic align_mode_in,
	input wire logic recovered_bit_clk_in,
	input wire logic serial_bit_in,
	input wire logic user_ready_in,
	output rsa_pkg::rsa_entry_t rx_entry_out,
	output logic rx_entry_valid_out,
	output logic rx_aligned_out,
	output logic rx_overflow_out
);
	import rsa_pkg::*;
	logic req, next_req, ack, rd_rst, lrst, lmode, found, wready;
	logic cv, next_cv, aligned, next_aligned, ovf, next_ovf, wv, next_wv;
	logic [`RSA_CHAR_BITS-1:0] sr, next_sr, chr, next_chr, pick;
	logic [`RSA_CHAR_BITS-1:0] reg_a, next_reg_a, reg_b, next_reg_b;
	logic [`RSA_PAIR_BITS-1:0] pair;
	logic [3:0] bitcnt, next_bitcnt, pcnt, next_pcnt, off, next_off, hit;
	logic [1:0] ccnt, next_ccnt;
	logic [29:0] wbuf, next_wbuf;
	logic [`RSA_WORD_BITS-1:0] word;
	rsa_entry_t went, next_went;

	always_comb begin
		next_req = rst_in || link_reinit_in;
		// read side drops its entry on the very edge reset is seen
		rd_rst = next_req || req || ack;
	end

	always_ff @(posedge ref_clk_in) begin
		req <= next_req;
	end

	rsa_sync3 #(.W(2)) u_to_link (
		.clk_in(recovered_bit_clk_in),
		.rst_in(1'b0),
		.d_in({req, align_mode_in}),
		.q_out({lrst, lmode})
	);

	rsa_sync3 #(.W(3)) u_to_user (
		.clk_in(ref_clk_in),
		.rst_in(next_req),
		.d_in({lrst, aligned, ovf}),
		.q_out({ack, rx_aligned_out, rx_overflow_out})
	);

	always_comb begin
		next_sr = {sr[`RSA_CHAR_BITS-2:0], serial_bit_in};
		next_bitcnt = bitcnt;
		next_pcnt = pcnt;
		next_reg_a = reg_a;
		next_reg_b = reg_b;
		next_off = off;
		next_chr = chr;
		next_cv = 1'b0;
		next_aligned = aligned;
		next_ccnt = ccnt;
		next_wbuf = wbuf;
		next_went = went;
		next_wv = 1'b0;
		next_ovf = ovf;
		pair = {reg_b, reg_a};
		found = 1'b0;
		hit = off;
		for (int o = 0; o < `RSA_OFFSETS; o++) begin
			if (is_comma(pair[19-o -: `RSA_CHAR_BITS])) begin
				found = 1'b1;
				hit = 4'(o);
			end
		end
		pick = pair[19-hit -: `RSA_CHAR_BITS];
		word = {wbuf, chr};
		if (!lmode) begin
			// comma in shift register loads at once
			if (is_comma(sr)) begin
				next_chr = sr;
				next_cv = 1'b1;
				next_bitcnt = 4'h0;
				next_aligned = 1'b1;
			end else if (bitcnt == `RSA_BIT_LAST) begin
				next_chr = sr;
				next_cv = 1'b1;
				next_bitcnt = 4'h0;
			end else begin
				next_bitcnt = bitcnt + 4'h1;
			end
		end else begin
			if (pcnt == `RSA_BIT_LAST) begin
				next_pcnt = 4'h0;
				next_reg_a = sr;
				next_reg_b = reg_a;
				if (found) begin
					next_off = hit;
					next_aligned = 1'b1;
				end
				next_chr = pick;
				next_cv = aligned || found;
			end else begin
				next_pcnt = pcnt + 4'h1;
			end
		end
		if (cv) begin
			next_wbuf = {wbuf[19:0], chr};
			next_ccnt = ccnt + 2'h1;
			if (is_comma(chr)) begin
				next_ccnt = 2'h1;
			end else if (ccnt == `RSA_WORD_LAST) begin
				next_wv = aligned;
				next_went.data = word;
				next_went.skip = is_comma(word[39:30]) &&
					(word[29:0] == `RSA_SKIP_TAIL);
			end
		end
		// the line cannot stall, so a refused word is lost
		if (wv && !wready) begin
			next_ovf = 1'b1;
		end
	end

	always_ff @(posedge recovered_bit_clk_in) begin
		if (lrst) begin
			sr <= '0;
			chr <= '0;
			reg_a <= '0;
			reg_b <= '0;
			bitcnt <= 4'h0;
			pcnt <= 4'h0;
			off <= 4'h0;
			cv <= 1'b0;
			aligned <= 1'b0;
			ovf <= 1'b0;
			ccnt <= 2'h0;
			wbuf <= '0;
			went <= '0;
			wv <= 1'b0;
		end else begin
			sr <= next_sr;
			chr <= next_chr;
			reg_a <= next_reg_a;
			reg_b <= next_reg_b;
			bitcnt <= next_bitcnt;
			pcnt <= next_pcnt;
			off <= next_off;
			cv <= next_cv;
			aligned <= next_aligned;
			ovf <= next_ovf;
			ccnt <= next_ccnt;
			wbuf <= next_wbuf;
			went <= next_went;
			wv <= next_wv;
		end
	end

	rsa_elastic_fifo #(
		.WIDTH($bits(rsa_entry_t)),
		.DEPTH(`RSA_FIFO_DEPTH)
	) u_ebuf (
		.wr_clk_in(recovered_bit_clk_in),
		.wr_rst_in(lrst),
		.wr_data_in(went),
		.wr_valid_in(wv),
		.wr_ready_out(wready),
		.rd_clk_in(ref_clk_in),
		.rd_rst_in(rd_rst),
		.rd_data_out(rx_entry_out),
		.rd_valid_out(rx_entry_valid_out),
		.rd_ready_in(user_ready_in)
	);
endmodule
